// ### pcs_core.sv
// pcs_core.sv: program counter, high latch and 16-entry return stack,
// with an APB slave for the software-visible registers.
// assumes: one clock, the instruction logic presents one operation a cycle
// on cpu_req, and an external reset controller acts on stack_fault_reset.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "pcs_defs.svh"

module pcs_core #(
   parameter int STK_DEPTH = `PCS_DEPTH,
   parameter logic [`PCS_PC_W-1:0] IRQ_VECTOR = 15'h0004
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pcs_pkg::pcs_req_s cpu_req,
   output logic [`PCS_PC_W-1:0] pc_value,
   output logic stack_fault_reset
);

   ////////////////////////////////////////////////////////////////////////
   // elaboration checks

   if (STK_DEPTH != `PCS_DEPTH)
   begin : g_bad_depth
      $error("pcs_core: stack depth must be 16");
   end

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [11:0] reg_index(input logic [15:0] a);
      reg_index = a[13:2];
   endfunction : reg_index

   function automatic logic addr_ok(input logic [15:0] a);
      logic [11:0] i;
      i = a[13:2];
      addr_ok = (a[1:0] == 2'h0) && (a[15:14] == 2'h0) &&
                ((i == `PCS_IDX_SP) || (i == `PCS_IDX_TOP_OF_STACK_LOW) ||
                 (i == `PCS_IDX_TOP_OF_STACK_HIGH) || (i == `PCS_IDX_PCL) ||
                 (i == `PCS_IDX_LATCH) || (i == `PCS_IDX_CTRL) ||
                 (i == `PCS_IDX_STAT));
   endfunction : addr_ok

   // full-width wrap-around sum
   function automatic logic [`PCS_PC_W-1:0] pc_add(
      input logic [`PCS_PC_W-1:0] base,
      input logic [`PCS_PC_W-1:0] off
   );
      pc_add = base + off;
   endfunction : pc_add

   localparam pcs_pkg::pcs_state_s ST_RST = '{
      pc: `PCS_PC_RST,
      latch: `PCS_LATCH_RST,
      sp: `PCS_SP_RST,
      stk: '0,
      ovf: 1'b0,
      unf: 1'b0,
      fault_en: `PCS_FAULT_EN_RST,
      fault_req: 1'b0,
      rdata: 32'h0000_0000
   };

   ////////////////////////////////////////////////////////////////////////
   // state

   pcs_pkg::pcs_state_s st_reg;
   pcs_pkg::pcs_state_s st_next;

   logic setup;
   logic apb_wr;
   logic [11:0] idx;
   logic bad;

   assign setup = psel && !penable;
   assign idx = reg_index(paddr);
   assign bad = !addr_ok(paddr);
   assign apb_wr = psel && penable && pwrite && !bad;

   assign pready = psel && penable;
   assign pslverr = psel && penable && bad;
   assign prdata = st_reg.rdata;
   assign pc_value = st_reg.pc;
   assign stack_fault_reset = st_reg.fault_req;

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      logic do_push;
      logic do_pop;
      logic [`PCS_SP_W-1:0] sp_inc;
      logic [`PCS_PC_W-1:0] push_val;
      logic [`PCS_PC_W-1:0] pc_inc;
      logic [3:0] sel;
      do_push = 1'b0;
      do_pop = 1'b0;
      sp_inc = '0;
      push_val = '0;
      pc_inc = '0;
      sel = '0;
      st_next = st_reg;
      st_next.fault_req = 1'b0;
      sel = st_reg.sp[3:0];

      // read data captured in the setup cycle
      if (setup)
      begin
         st_next.rdata = 32'h0000_0000;
         if (!bad)
         begin
            unique case (idx)
               `PCS_IDX_SP: st_next.rdata[4:0] = st_reg.sp;
               `PCS_IDX_TOP_OF_STACK_LOW: st_next.rdata[7:0] = st_reg.stk[sel][7:0];
               `PCS_IDX_TOP_OF_STACK_HIGH: st_next.rdata[6:0] = st_reg.stk[sel][14:8];
               `PCS_IDX_PCL: st_next.rdata[7:0] = st_reg.pc[7:0];
               `PCS_IDX_LATCH: st_next.rdata[6:0] = st_reg.latch;
               `PCS_IDX_CTRL: st_next.rdata[`PCS_CTRL_FAULT_EN_BIT] = st_reg.fault_en;
               default:
               begin
                  st_next.rdata[`PCS_STAT_OVF_BIT] = st_reg.ovf;
                  st_next.rdata[`PCS_STAT_UNF_BIT] = st_reg.unf;
               end
            endcase
         end
      end

      // register writes take effect at the access edge
      if (apb_wr)
      begin
         unique case (idx)
            `PCS_IDX_SP: st_next.sp = pwdata[4:0];
            `PCS_IDX_TOP_OF_STACK_LOW: st_next.stk[sel][7:0] = pwdata[7:0];
            `PCS_IDX_TOP_OF_STACK_HIGH: st_next.stk[sel][14:8] = pwdata[6:0];
            `PCS_IDX_PCL: st_next.pc = {st_reg.latch, pwdata[7:0]};
            `PCS_IDX_LATCH: st_next.latch = pwdata[6:0];
            `PCS_IDX_CTRL: st_next.fault_en = pwdata[`PCS_CTRL_FAULT_EN_BIT];
            default:
            begin
               // write one to clear; a same-cycle event sets it again below
               if (pwdata[`PCS_STAT_OVF_BIT])
                  st_next.ovf = 1'b0;
               if (pwdata[`PCS_STAT_UNF_BIT])
                  st_next.unf = 1'b0;
            end
         endcase
      end

      // instruction side; it follows the bus so it wins on the counter
      pc_inc = pc_add(st_reg.pc, 15'h0001);
      push_val = st_reg.pc;
      unique case (cpu_req.op)
         pcs_pkg::PCS_OP_ADV: st_next.pc = pc_inc;
         pcs_pkg::PCS_OP_WRPCL: st_next.pc = {st_reg.latch, cpu_req.data};
         pcs_pkg::PCS_OP_CALL:
         begin
            do_push = 1'b1;
            st_next.pc = {st_reg.latch[6:`PCS_LATCH_CALL_LSB], cpu_req.operand};
         end
         pcs_pkg::PCS_OP_INDIRECT_SUBROUTINE_JUMP:
         begin
            do_push = 1'b1;
            st_next.pc = {st_reg.latch, cpu_req.wreg};
         end
         pcs_pkg::PCS_OP_IRQ:
         begin
            do_push = 1'b1;
            st_next.pc = IRQ_VECTOR;
         end
         pcs_pkg::PCS_OP_BRW:
            st_next.pc = pc_add(pc_inc, {7'h00, cpu_req.wreg});
         pcs_pkg::PCS_OP_BRA:
            st_next.pc = pc_add(pc_inc, {{(`PCS_PC_W-`PCS_BRA_MSB-1){
               cpu_req.operand[`PCS_BRA_MSB]}},
               cpu_req.operand[`PCS_BRA_MSB:0]});
         pcs_pkg::PCS_OP_RET,
         pcs_pkg::PCS_OP_LITERAL_RETURN,
         pcs_pkg::PCS_OP_INTERRUPT_RETURN: do_pop = 1'b1;
         default: ;
      endcase

      // stack moves never touch the latch
      sp_inc = st_reg.sp + 5'h01;
      if (do_push)
      begin
         if (sp_inc[4])
         begin
            st_next.ovf = 1'b1;
            st_next.fault_req = st_reg.fault_en;
         end
         if (!(sp_inc[4] && st_reg.fault_en))
         begin
            st_next.sp = sp_inc;
            st_next.stk[sp_inc[3:0]] = push_val;
         end
      end
      if (do_pop)
      begin
         st_next.pc = st_reg.stk[sel];
         st_next.sp = st_reg.sp - 5'h01;
         if (st_reg.sp == `PCS_SP_RST)
         begin
            st_next.unf = 1'b1;
            st_next.fault_req = st_reg.fault_en;
         end
      end

      // stack fault reset returns counter and pointer to their reset state
      if (st_next.fault_req)
      begin
         st_next.pc = `PCS_PC_RST;
         st_next.sp = `PCS_SP_RST;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         st_reg <= ST_RST;
      else
         st_reg <= st_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   logic quiet;
   logic push_trips;
   logic op_push;
   logic op_pop;
   assign quiet = !apb_wr;
   // with fault reset on, a push from pointer 0x0f up to 0x1e trips the reset
   assign push_trips = st_reg.fault_en && (st_reg.sp inside {[5'h0f:5'h1e]});
   assign op_push = cpu_req.op inside {pcs_pkg::PCS_OP_CALL, pcs_pkg::PCS_OP_INDIRECT_SUBROUTINE_JUMP,
      pcs_pkg::PCS_OP_IRQ};
   assign op_pop = cpu_req.op inside {pcs_pkg::PCS_OP_RET, pcs_pkg::PCS_OP_LITERAL_RETURN,
      pcs_pkg::PCS_OP_INTERRUPT_RETURN};

   sequence s_push_first;
      quiet && st_reg.sp == 5'h1f && cpu_req.op == pcs_pkg::PCS_OP_CALL;
   endsequence

   sequence s_push_over;
      quiet && st_reg.sp == 5'h0f && cpu_req.op == pcs_pkg::PCS_OP_IRQ;
   endsequence

   sequence s_push_trip;
      quiet && op_push && push_trips;
   endsequence

   sequence s_pop_last;
      quiet && st_reg.sp == 5'h00 && cpu_req.op == pcs_pkg::PCS_OP_RET;
   endsequence

   sequence s_pop_empty_fault;
      quiet && st_reg.fault_en && st_reg.sp == 5'h1f && op_pop;
   endsequence

   sequence s_fault_pulse;
      stack_fault_reset && pc_value == 15'h0000 ##1 !stack_fault_reset;
   endsequence

   AST_RESET_PC: assert property (@(posedge sys_clk) disable iff (1'b0)
      !rst_n |=> pc_value == 15'h0000 && st_reg.sp == 5'h1f)
      else $error("counter or pointer not cleared by reset");

   AST_FIRST_PUSH: assert property (s_push_first |=> st_reg.sp == 5'h00 &&
      st_reg.stk[0] == $past(pc_value))
      else $error("first push did not use entry zero");

   AST_CALL_TGT: assert property (quiet && cpu_req.op == pcs_pkg::PCS_OP_CALL &&
      !push_trips |=> pc_value == {$past(st_reg.latch[6:3]), $past(cpu_req.operand)})
      else $error("absolute call target wrong");

   AST_INDIRECT_SUBROUTINE_JUMP_TGT: assert property (quiet && cpu_req.op == pcs_pkg::PCS_OP_INDIRECT_SUBROUTINE_JUMP &&
      !push_trips |=> pc_value == {$past(st_reg.latch), $past(cpu_req.wreg)})
      else $error("computed call target wrong");

   AST_BRW_TGT: assert property (quiet && cpu_req.op == pcs_pkg::PCS_OP_BRW
      |=> pc_value == 15'($past(pc_value) + 15'h0001 + {7'h00, $past(cpu_req.wreg)}))
      else $error("accumulator branch target wrong");

   AST_BRA_BACK: assert property (quiet && cpu_req.op == pcs_pkg::PCS_OP_BRA &&
      cpu_req.operand[8:0] == 9'h1ff |=> pc_value == $past(pc_value))
      else $error("relative branch of minus one did not stay put");

   AST_BRA_FWD: assert property (quiet && cpu_req.op == pcs_pkg::PCS_OP_BRA &&
      cpu_req.operand[8:0] == 9'h0ff |=> pc_value == $past(pc_value) + 15'h0100)
      else $error("relative branch did not cross into the next block");

   AST_LATCH_KEEP: assert property (quiet && (op_push || op_pop) |=>
      $stable(st_reg.latch))
      else $error("stack move changed the latch");

   AST_OVF_WRAP: assert property (s_push_over ##0 !st_reg.fault_en |=> st_reg.ovf &&
      st_reg.sp == 5'h10 && st_reg.stk[0] == $past(pc_value))
      else $error("wrapping push did not overwrite entry zero");

   AST_OVF_FAULT: assert property (s_push_trip |=> stack_fault_reset && st_reg.ovf &&
      st_reg.sp == 5'h1f && pc_value == 15'h0000)
      else $error("overflow with fault reset enabled did not reset");

   AST_FAULT_RST: assert property (s_pop_empty_fault |=> s_fault_pulse)
      else $error("underflow with fault reset enabled did not reset");

   AST_POP_EMPTY: assert property (s_pop_last ##0 !st_reg.fault_en |=>
      st_reg.sp == 5'h1f && pc_value == $past(st_reg.stk[0]) && !st_reg.unf [*2])
      else $error("popping last entry did not empty the stack");

   AST_PUSH_STEP: assert property (quiet && op_push && !push_trips |=>
      st_reg.sp == $past(st_reg.sp) + 5'h01 &&
      st_reg.stk[$past(st_reg.sp[3:0]) + 4'h1] == $past(pc_value))
      else $error("push did not raise the pointer and store the counter");

   AST_POP_STEP: assert property (quiet && op_pop && !(st_reg.fault_en &&
      st_reg.sp == 5'h1f) |=> pc_value == $past(st_reg.stk[st_reg.sp[3:0]]) &&
      st_reg.sp == $past(st_reg.sp) - 5'h01)
      else $error("pop did not load the counter and lower the pointer");

   AST_UNF_FLAG: assert property (op_pop && st_reg.sp == 5'h1f |=> st_reg.unf)
      else $error("pop of the empty stack did not flag underflow");

   AST_FLAG_HOLD: assert property (st_reg.ovf && !(apb_wr && idx == `PCS_IDX_STAT) |=>
      st_reg.ovf)
      else $error("overflow flag cleared without a status write");

   AST_WRPCL_TGT: assert property (cpu_req.op == pcs_pkg::PCS_OP_WRPCL |=>
      pc_value == {$past(st_reg.latch), $past(cpu_req.data)})
      else $error("low byte write did not load the latch into the upper bits");

   AST_BUS_PCL: assert property (apb_wr && idx == `PCS_IDX_PCL &&
      cpu_req.op == pcs_pkg::PCS_OP_NONE |=>
      pc_value == {$past(st_reg.latch), $past(pwdata[7:0])})
      else $error("bus write of the low byte did not load the whole counter");

   AST_IRQ_TGT: assert property (cpu_req.op == pcs_pkg::PCS_OP_IRQ && !push_trips |=>
      pc_value == IRQ_VECTOR)
      else $error("interrupt did not load the vector");

   AST_ADVANCE: assert property (quiet && cpu_req.op == pcs_pkg::PCS_OP_ADV
      |=> pc_value == 15'($past(pc_value) + 15'h0001))
      else $error("sequential advance wrong");

endmodule : pcs_core

// ### pcs_cpu_model.sv
// pcs_cpu_model.sv: instruction-side partner that presents one operation a cycle.
// assumes: the core samples cpu_req at every rising edge of sys_clk.
`timescale 1ns/1ps

module pcs_cpu_model (
   input wire logic sys_clk,
   output pcs_pkg::pcs_req_s cpu_req
);

   initial cpu_req = '0;

   // holds one op for exactly one edge, then idles; pushes come only when asked
   task automatic issue(input pcs_pkg::pcs_op_e code, input logic [10:0] opnd,
      input logic [7:0] w);
      @(posedge sys_clk);
      cpu_req <= '{op: code, operand: opnd, wreg: w, data: w};
      @(posedge sys_clk);
      cpu_req.op <= pcs_pkg::PCS_OP_NONE;
      #1;
   endtask : issue

endmodule : pcs_cpu_model

// ### pcs_defs.svh
// pcs_defs.svh: offsets, field positions, reset values and widths of the
// program counter and return stack block.
// assumes: included by bare name from pcs_pkg.sv and pcs_core.sv.
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

// register indices, byte address is four times the index
`define PCS_IDX_SP 12'hfed
`define PCS_IDX_TOP_OF_STACK_LOW 12'hfee
`define PCS_IDX_TOP_OF_STACK_HIGH 12'hfef
`define PCS_IDX_PCL 12'hf00
`define PCS_IDX_LATCH 12'hf01
`define PCS_IDX_CTRL 12'hf02
`define PCS_IDX_STAT 12'hf03

// field positions
`define PCS_CTRL_FAULT_EN_BIT 0
`define PCS_STAT_OVF_BIT 0
`define PCS_STAT_UNF_BIT 1
`define PCS_CALL_SPLIT 11
`define PCS_LATCH_CALL_LSB 3
`define PCS_BRA_MSB 8

// widths
`define PCS_PC_W 15
`define PCS_SP_W 5
`define PCS_LATCH_W 7
`define PCS_DEPTH 16

// reset values, and the pointer of the last stack entry
`define PCS_PC_RST 15'h0000
`define PCS_SP_RST 5'h1f
`define PCS_SP_LAST 5'h0f
`define PCS_LATCH_RST 7'h00
`define PCS_FAULT_EN_RST 1'b1

`endif

// ### pcs_pkg.sv
// pcs_pkg.sv: types shared by the program counter and return stack block.
// assumes: pcs_defs.svh supplies the widths.
`include "pcs_defs.svh"

package pcs_pkg;

   typedef enum logic [3:0] {
      PCS_OP_NONE = 4'h0,
      PCS_OP_ADV = 4'h1,
      PCS_OP_WRPCL = 4'h2,
      PCS_OP_CALL = 4'h3,
      PCS_OP_INDIRECT_SUBROUTINE_JUMP = 4'h4,
      PCS_OP_BRW = 4'h5,
      PCS_OP_BRA = 4'h6,
      PCS_OP_RET = 4'h7,
      PCS_OP_LITERAL_RETURN = 4'h8,
      PCS_OP_INTERRUPT_RETURN = 4'h9,
      PCS_OP_IRQ = 4'ha
   } pcs_op_e;

   typedef struct packed {
      pcs_op_e op;
      logic [10:0] operand;
      logic [7:0] wreg;
      logic [7:0] data;
   } pcs_req_s;

   typedef struct packed {
      logic [`PCS_PC_W-1:0] pc;
      logic [`PCS_LATCH_W-1:0] latch;
      logic [`PCS_SP_W-1:0] sp;
      logic [`PCS_DEPTH-1:0][`PCS_PC_W-1:0] stk;
      logic ovf;
      logic unf;
      logic fault_en;
      logic fault_req;
      logic [31:0] rdata;
   } pcs_state_s;

endpackage : pcs_pkg

// ### pcs_tb.sv
// pcs_tb.sv: self-checking bench for the counter and return stack core.
// assumes: zero-wait APB slave and the partner model pcs_cpu_model.
`timescale 1ns/1ps
`include "pcs_defs.svh"

module pcs_tb;

   localparam logic [14:0] IRQV = 15'h0123;
   logic sys_clk;
   logic rst_n;
   logic psel;
   logic penable;
   logic pwrite;
   logic [15:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   pcs_pkg::pcs_req_s cpu_req;
   logic [14:0] pc_value;
   logic stack_fault_reset;
   logic [31:0] rd;
   logic err;
   int bad_count = 0;
   int samples_checked = 0;
   int pulses = 0;

   pcs_core #(.IRQ_VECTOR(IRQV)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req),
      .pc_value(pc_value), .stack_fault_reset(stack_fault_reset));

   pcs_cpu_model cpu (.sys_clk(sys_clk), .cpu_req(cpu_req));

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
      if (stack_fault_reset === 1'b1)
         pulses <= pulses + 1;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #200000;
      bad_count++;
      tally_and_finish();
   end

   initial
   begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      check(32'(pc_value), 32'h0);
      apb(1'b0, `PCS_IDX_SP, 0);
      check(rd, 32'h1f);
      $display("test reset done");

      apb(1'b1, `PCS_IDX_LATCH, 32'h12);
      apb(1'b1, `PCS_IDX_PCL, 32'h34);
      check(32'(pc_value), 32'h1234);
      apb(1'b0, `PCS_IDX_PCL, 0);
      check(rd, 32'h34);
      cpu.issue(pcs_pkg::PCS_OP_ADV, 0, 0);
      check(32'(pc_value), 32'h1235);
      $display("test counter done");

      cpu.issue(pcs_pkg::PCS_OP_CALL, 11'h5a5, 0);
      check(32'(pc_value), 32'h15a5);
      apb(1'b0, `PCS_IDX_SP, 0);
      check(rd, 32'h0);
      apb(1'b0, `PCS_IDX_TOP_OF_STACK_LOW, 0);
      check(rd, 32'h35);
      apb(1'b0, `PCS_IDX_TOP_OF_STACK_HIGH, 0);
      check(rd, 32'h12);
      apb(1'b0, `PCS_IDX_LATCH, 0);
      check(rd, 32'h12);
      cpu.issue(pcs_pkg::PCS_OP_BRA, 11'h1ff, 0);
      check(32'(pc_value), 32'h15a5);
      cpu.issue(pcs_pkg::PCS_OP_BRA, 11'h0ff, 0);
      check(32'(pc_value), 32'h16a5);
      cpu.issue(pcs_pkg::PCS_OP_BRW, 0, 8'hff);
      check(32'(pc_value), 32'h17a5);
      cpu.issue(pcs_pkg::PCS_OP_INDIRECT_SUBROUTINE_JUMP, 0, 8'h77);
      check(32'(pc_value), 32'h1277);
      cpu.issue(pcs_pkg::PCS_OP_RET, 0, 0);
      check(32'(pc_value), 32'h17a5);
      cpu.issue(pcs_pkg::PCS_OP_LITERAL_RETURN, 0, 0);
      check(32'(pc_value), 32'h1235);
      apb(1'b0, `PCS_IDX_SP, 0);
      check(rd, 32'h1f);
      $display("test stack done");

      cpu.issue(pcs_pkg::PCS_OP_INTERRUPT_RETURN, 0, 0);
      repeat (2) @(posedge sys_clk);
      #1;
      check(32'(pulses), 32'h1);
      check(32'(pc_value), 32'h0);
      apb(1'b0, `PCS_IDX_STAT, 0);
      check(rd, 32'h2);
      apb(1'b1, `PCS_IDX_STAT, 32'h3);
      apb(1'b0, `PCS_IDX_STAT, 0);
      check(rd, 32'h0);
      $display("test fault done");

      apb(1'b1, `PCS_IDX_CTRL, 32'h0);
      for (int i = 0; i < 17; i++)
      begin
         cpu.issue(pcs_pkg::PCS_OP_WRPCL, 0, 8'(i));
         cpu.issue(pcs_pkg::PCS_OP_IRQ, 0, 0);
         check(32'(pc_value), 32'(IRQV));
      end
      apb(1'b0, `PCS_IDX_SP, 0);
      check(rd, 32'h10);
      apb(1'b0, `PCS_IDX_TOP_OF_STACK_LOW, 0);
      check(rd, 32'h10);
      apb(1'b0, `PCS_IDX_STAT, 0);
      check(rd, 32'h1);
      check(32'(pulses), 32'h1);
      // no interrupt between pointer move and entry access
      apb(1'b1, `PCS_IDX_SP, 32'h1);
      apb(1'b1, `PCS_IDX_TOP_OF_STACK_LOW, 32'hab);
      apb(1'b0, `PCS_IDX_TOP_OF_STACK_LOW, 0);
      check(rd, 32'hab);
      apb(1'b0, `PCS_IDX_TOP_OF_STACK_HIGH, 0);
      check(rd, 32'h12);
      cpu.issue(pcs_pkg::PCS_OP_RET, 0, 0);
      check(32'(pc_value), 32'h12ab);
      apb(1'b0, `PCS_IDX_SP, 0);
      check(rd, 32'h0);
      cpu.issue(pcs_pkg::PCS_OP_RET, 11'h000, 8'h00);
      check(32'(pc_value), 32'h1210);
      apb(1'b0, `PCS_IDX_SP, 0);
      check(rd, 32'h1f);
      $display("test wrap done");

      apb(1'b1, `PCS_IDX_TOP_OF_STACK_HIGH, 32'hff);
      apb(1'b0, `PCS_IDX_TOP_OF_STACK_HIGH, 0);
      check(rd, 32'h7f);
      apb(1'b1, 12'h100, 32'h55);
      check(32'(err), 32'h1);
      apb(1'b0, 12'h100, 0);
      check(rd, 32'h0);
      $display("test bus done");
      apb(1'b1, `PCS_IDX_STAT, 32'h3);
      apb(1'b1, `PCS_IDX_CTRL, 32'h1);
      apb(1'b1, `PCS_IDX_SP, 32'hf);
      cpu.issue(pcs_pkg::PCS_OP_CALL, 11'h001, 8'h00);
      check(32'(stack_fault_reset), 32'h1);
      check(32'(pc_value), 32'h0);
      apb(1'b0, `PCS_IDX_SP, 0);
      check(rd, 32'h1f);
      apb(1'b0, `PCS_IDX_STAT, 0);
      check(rd, 32'h1);
      check(32'(pulses), 32'h2);
      $display("test overflow fault done");
      tally_and_finish();
   end

endmodule : pcs_tb
